// *** level_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module level_sync
  import supply_monitor_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // Two flops per bit; only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

// *** low_voltage_detect_flags.sv ***
// Notes on behaviour
// - Detect level chosen by software select
// - Low-power modes disable detection entirely
// - Detect flag set while below threshold
// - Detect ack clears only after recovery
// - Warning flag set while below warning
// - Warning ack clears only after recovery
// - Reset enable requests reset on detection
// - Reset held until supply recovers
// - Source flag set by detect reset or power-on
// - Interrupt mode raises detect request
// - Warning interrupt while flag and enable
// - Four warning levels per detect level
// - Warning threshold above detect threshold
// - Level code 00 low, 01 high
// - Reset enable is write once
// - Detect ack reads as zero
// - User-mode writes refused with error
`timescale 1ns/100ps
`default_nettype none
module low_voltage_detect_flags
  import supply_monitor_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  input  wire logic [3:0]         pstrb,
  input  wire logic [2:0]         pprot,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire comparator_levels_t comparators,
  input  wire logic               power_on_reset_seen,
  output monitor_requests_t       requests,
  output logic      [1:0]         detect_level_select,
  output logic      [1:0]         warning_level_select
);

  localparam int CMP_W = $bits(comparator_levels_t);

  comparator_levels_t cmp_sync;
  logic [CMP_W-1:0]   cmp_sync_bits;
  logic               por_sync;

  level_sync #(
    .WIDTH (CMP_W + 1)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({comparators, power_on_reset_seen}),
    .sync_out ({cmp_sync_bits, por_sync})
  );
  assign cmp_sync = comparator_levels_t'(cmp_sync_bits);

  // Control and state
  logic       detect_flag;
  logic       warning_flag;
  logic       detect_irq_enable;
  logic       detect_reset_enable;
  logic       reset_enable_locked;
  logic       warning_irq_enable;
  logic       very_low_power_modes;
  logic       low_leakage_stop;
  logic       reset_hold;
  logic       reset_source_lowsupply;
  logic       next_detect_flag;
  logic       next_warning_flag;
  logic       next_reset_hold;

  // Bus decode
  wire        access_phase   = psel & penable;
  wire        supervisor     = pprot[0];
  wire        wr_attempt     = access_phase & pwrite;
  wire        wr_ok          = wr_attempt & supervisor & pstrb[0];
  wire        hit_detect     = (paddr == DETECT_STATUS_CONTROL_ADDR);
  wire        hit_warning    = (paddr == WARNING_STATUS_CONTROL_ADDR);
  wire        hit_status     = (paddr == MONITOR_STATUS_ADDR);
  wire        hit_mode       = (paddr == MODE_CONTROL_ADDR);
  wire        mapped         = hit_detect | hit_warning | hit_status | hit_mode;
  wire        wr_detect      = wr_ok & hit_detect;
  wire        wr_warning     = wr_ok & hit_warning;
  wire        wr_mode        = wr_ok & hit_mode;
  wire        detect_ack_strobe  = wr_detect & pwdata[DETECT_ACK_BIT];
  wire        warning_ack_strobe = wr_warning & pwdata[WARNING_ACK_BIT];

  // User writes and unmapped addresses answer with error
  assign pready  = 1'b1;
  assign pslverr = access_phase & (~mapped | (pwrite & ~supervisor));

  // Detection disabled in any low-power mode
  wire        detect_on = ~(very_low_power_modes | low_leakage_stop);

  // Threshold choice; code 01 high, others low
  wire        level_high = (detect_level_select == DETECT_LEVEL_HIGH);
  wire        below_detect_raw = level_high ? cmp_sync.below_detect_high
                                            : cmp_sync.below_detect_low;
  // Warning level picked within detect level's set of four
  wire [3:0]  warn_set = level_high ? cmp_sync.below_warning_high
                                    : cmp_sync.below_warning_low;
  wire        below_warning_raw = warn_set[warning_level_select];
  // Warning also asserted whenever detect trips
  wire        below_detect  = detect_on & below_detect_raw;
  wire        below_warning = detect_on & (below_warning_raw | below_detect_raw);

  // Level set wins; ack clears only once recovered
  always_comb begin
    next_detect_flag = detect_flag;
    if (below_detect) begin
      next_detect_flag = 1'b1;
    end else if (detect_ack_strobe) begin
      next_detect_flag = 1'b0;
    end
  end

  // Warning flag set and guarded clear
  always_comb begin
    next_warning_flag = warning_flag;
    if (below_warning) begin
      next_warning_flag = 1'b1;
    end else if (warning_ack_strobe) begin
      next_warning_flag = 1'b0;
    end
  end

  // Reset asserted on detection, held until recovery
  always_comb begin
    next_reset_hold = reset_hold;
    if (detect_reset_enable & below_detect) begin
      next_reset_hold = 1'b1;
    end else if (~below_detect) begin
      next_reset_hold = 1'b0;
    end
  end

  // Flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_flag  <= 1'b0;
      warning_flag <= 1'b0;
      reset_hold   <= 1'b0;
    end else begin
      detect_flag  <= next_detect_flag;
      warning_flag <= next_warning_flag;
      reset_hold   <= next_reset_hold;
    end
  end

  // Source flag sticky on detect reset or power-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_source_lowsupply <= 1'b0;
    end else if (reset_hold | por_sync) begin
      reset_source_lowsupply <= 1'b1;
    end
  end

  // Detect control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_irq_enable   <= 1'b0;
      detect_level_select <= DETECT_LEVEL_RESET;
    end else if (wr_detect) begin
      detect_irq_enable   <= pwdata[DETECT_IRQ_EN_BIT];
      detect_level_select <= pwdata[DETECT_LEVEL_LSB +: 2];
    end
  end

  // Reset enable locks after its first write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_reset_enable <= RESET_EN_RESET;
      reset_enable_locked <= 1'b0;
    end else if (wr_detect & ~reset_enable_locked) begin
      detect_reset_enable <= pwdata[DETECT_RESET_EN_BIT];
      reset_enable_locked <= 1'b1;
    end
  end

  // Warning control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warning_irq_enable   <= 1'b0;
      warning_level_select <= WARNING_LEVEL_RESET;
    end else if (wr_warning) begin
      warning_irq_enable   <= pwdata[WARNING_IRQ_EN_BIT];
      warning_level_select <= pwdata[WARNING_LEVEL_LSB +: 2];
    end
  end

  // Power mode indications from software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      very_low_power_modes <= 1'b0;
      low_leakage_stop     <= 1'b0;
    end else if (wr_mode) begin
      very_low_power_modes <= pwdata[MODE_VLP_BIT];
      low_leakage_stop     <= pwdata[MODE_VLLS_BIT];
    end
  end

  // Read words; ack bits always read zero
  logic [31:0] detect_word;
  logic [31:0] warning_word;
  logic [31:0] status_word;
  logic [31:0] mode_word;
  always_comb begin
    detect_word  = '0;
    warning_word = '0;
    status_word  = '0;
    mode_word    = '0;
    detect_word[DETECT_FLAG_BIT]            = detect_flag;
    detect_word[DETECT_IRQ_EN_BIT]          = detect_irq_enable;
    detect_word[DETECT_RESET_EN_BIT]        = detect_reset_enable;
    detect_word[DETECT_LEVEL_LSB +: 2]      = detect_level_select;
    warning_word[WARNING_FLAG_BIT]          = warning_flag;
    warning_word[WARNING_IRQ_EN_BIT]        = warning_irq_enable;
    warning_word[WARNING_LEVEL_LSB +: 2]    = warning_level_select;
    status_word[STAT_BELOW_DETECT_BIT]      = below_detect;
    status_word[STAT_BELOW_WARNING_BIT]     = below_warning;
    status_word[STAT_DETECT_ON_BIT]         = detect_on;
    status_word[STAT_RESET_HOLD_BIT]        = reset_hold;
    status_word[STAT_RESET_SRC_BIT]         = reset_source_lowsupply;
    mode_word[MODE_VLP_BIT]                 = very_low_power_modes;
    mode_word[MODE_VLLS_BIT]                = low_leakage_stop;
  end

  wire [31:0] read_mux = hit_detect  ? detect_word  :
                         hit_warning ? warning_word :
                         hit_status  ? status_word  :
                         hit_mode    ? mode_word    : 32'h0000_0000;

  // Read data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= read_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      requests <= '0;
    end else begin
      requests.detect_irq             <= detect_flag & detect_irq_enable &
                                         ~detect_reset_enable;
      requests.warning_irq            <= warning_flag & warning_irq_enable;
      requests.reset_request          <= next_reset_hold;
      requests.reset_source_lowsupply <= reset_source_lowsupply;
    end
  end

endmodule
`default_nettype wire

// *** lvd_checker_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module lvd_checker
  import supply_monitor_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [2:0]        pprot,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              power_on_reset_seen,
  input wire monitor_requests_t requests,
  input wire logic [1:0]        detect_level_select,
  input wire logic [1:0]        warning_level_select
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase of a transfer
  wire acc = psel && penable;
  a_ready_always: assert property (pready)
    else $error("ready low");
  a_user_write_err: assert property (acc && pwrite && !pprot[0] |-> pslverr)
    else $error("user write accepted");
  a_unmapped_err: assert property (acc && paddr > 12'h00C |-> pslverr)
    else $error("unmapped access accepted");
  a_irq_or_reset: assert property (!(requests.detect_irq && requests.reset_request))
    else $error("interrupt and reset together");
  a_source_sticky: assert property (requests.reset_source_lowsupply |=>
    requests.reset_source_lowsupply)
    else $error("source flag lost");
  a_reset_source: assert property ($rose(requests.reset_request) |->
    ##[0:3] requests.reset_source_lowsupply)
    else $error("source flag missing after reset");
  a_por_source: assert property (power_on_reset_seen |->
    ##[1:4] requests.reset_source_lowsupply)
    else $error("source flag missing after power-on");
  a_detect_sel_write: assert property ($changed(detect_level_select) |->
    $past(acc && pwrite && paddr == 12'h000))
    else $error("detect level changed without write");
  a_warn_sel_write: assert property ($changed(warning_level_select) |->
    $past(acc && pwrite && paddr == 12'h004))
    else $error("warning level changed without write");
  c_detect_irq: cover property (requests.detect_irq);
  c_warning_irq: cover property (requests.warning_irq);
  c_reset_req: cover property (requests.reset_request);
endmodule
bind low_voltage_detect_flags lvd_checker lvd_checker_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pprot, .pready, .pslverr,
  .power_on_reset_seen, .requests, .detect_level_select, .warning_level_select
);
`default_nettype wire

// *** supply_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module supply_model
  import supply_monitor_pkg::*;
#(
  parameter int DET_LOW  = 1600,
  parameter int DET_HIGH = 2600,
  parameter int STEP     = 100
) (
  input  wire logic [15:0]        supply_mv,
  output var comparator_levels_t  comparators
);
  // Comparators at both detect trip levels
  assign comparators.below_detect_low  = int'(supply_mv) < DET_LOW;
  assign comparators.below_detect_high = int'(supply_mv) < DET_HIGH;
  // Four warning levels above each detect level, index 0 highest
  for (genvar i = 0; i < 4; i++) begin : g_warn
    assign comparators.below_warning_low[i]  = int'(supply_mv) < DET_LOW + STEP * (4 - i);
    assign comparators.below_warning_high[i] = int'(supply_mv) < DET_HIGH + STEP * (4 - i);
  end
endmodule
`default_nettype wire

// *** supply_monitor_pkg.sv ***
package supply_monitor_pkg;

  // Register byte addresses
  localparam logic [11:0] DETECT_STATUS_CONTROL_ADDR  = 12'h000;
  localparam logic [11:0] WARNING_STATUS_CONTROL_ADDR = 12'h004;
  localparam logic [11:0] MONITOR_STATUS_ADDR         = 12'h008;
  localparam logic [11:0] MODE_CONTROL_ADDR           = 12'h00C;

  // Detect status/control field positions
  localparam int DETECT_FLAG_BIT      = 7;
  localparam int DETECT_ACK_BIT       = 6;
  localparam int DETECT_IRQ_EN_BIT    = 5;
  localparam int DETECT_RESET_EN_BIT  = 4;
  localparam int DETECT_LEVEL_LSB     = 0;

  // Warning status/control field positions
  localparam int WARNING_FLAG_BIT     = 7;
  localparam int WARNING_ACK_BIT      = 6;
  localparam int WARNING_IRQ_EN_BIT   = 5;
  localparam int WARNING_LEVEL_LSB    = 0;

  // Monitor status field positions
  localparam int STAT_BELOW_DETECT_BIT  = 0;
  localparam int STAT_BELOW_WARNING_BIT = 1;
  localparam int STAT_DETECT_ON_BIT     = 2;
  localparam int STAT_RESET_HOLD_BIT    = 3;
  localparam int STAT_RESET_SRC_BIT     = 4;

  // Mode control field positions
  localparam int MODE_VLP_BIT  = 0;
  localparam int MODE_VLLS_BIT = 1;

  // Detect level codes
  localparam logic [1:0] DETECT_LEVEL_LOW  = 2'h0;
  localparam logic [1:0] DETECT_LEVEL_HIGH = 2'h1;

  // Reset values
  localparam logic [1:0] DETECT_LEVEL_RESET  = 2'h0;
  localparam logic [1:0] WARNING_LEVEL_RESET = 2'h0;
  localparam logic       RESET_EN_RESET      = 1'b1;

  // Comparator level inputs
  typedef struct packed {
    logic below_detect_low;
    logic below_detect_high;
    logic [3:0] below_warning_low;
    logic [3:0] below_warning_high;
  } comparator_levels_t;

  // Requests to the rest of the chip
  typedef struct packed {
    logic detect_irq;
    logic warning_irq;
    logic reset_request;
    logic reset_source_lowsupply;
  } monitor_requests_t;

endpackage

// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench
  import supply_monitor_pkg::*;
;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic               power_on_reset_seen;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata;
  logic [3:0]         pstrb;
  logic [2:0]         pprot;
  logic [15:0]        supply_mv;
  logic [1:0]         detect_level_select, warning_level_select;
  comparator_levels_t comparators;
  monitor_requests_t  requests;
  int                 n_errors, cmp_count;

  low_voltage_detect_flags low_voltage_detect_flags_inst (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pprot, .prdata,
    .pready, .pslverr, .comparators, .power_on_reset_seen, .requests,
    .detect_level_select, .warning_level_select
  );
  supply_model supply_model_inst (.supply_mv, .comparators);

  // Clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One transfer, held until pready, then judged
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     input logic sup, input logic err, input logic [7:0] ex);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h00_0000, d};
    pprot   <= {2'b00, sup};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    check("pslverr", {7'h00, pslverr}, {7'h00, err});
    if (!wr && !err) check("prdata", prdata[7:0], ex);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b1, 1'b0, 8'h00);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] ex);
    bus(1'b0, a, 8'h00, 1'b1, 1'b0, ex);
  endtask
  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic chk_req(input string nm, input logic seen, input logic exp);
    check(nm, {7'h00, seen}, {7'h00, exp});
  endtask

  task automatic t_regs();
    rd(12'h000, 8'h10);
    rd(12'h004, 8'h00);
    bus(1'b0, 12'h010, 8'h00, 1'b1, 1'b1, 8'h00);
    bus(1'b1, 12'h004, 8'h20, 1'b0, 1'b1, 8'h00);
    rd(12'h004, 8'h00);
    // Write with lane 0 disabled must leave the register alone
    pstrb <= 4'hE;
    wr(12'h004, 8'h23);
    pstrb <= 4'hF;
    rd(12'h004, 8'h00);
  endtask

  task automatic t_detect();
    wr(12'h000, 8'h21);
    wr(12'h000, 8'h11);
    rd(12'h000, 8'h01);
    check("level", {6'h00, detect_level_select}, 8'h01);
    wr(12'h000, 8'h20);
    supply_mv <= 16'h09C4; // 2500 mV
    settle();
    rd(12'h000, 8'h20);
    wr(12'h000, 8'h21);
    settle();
    rd(12'h000, 8'hA1);
    chk_req("detect_irq", requests.detect_irq, 1'b1);
    chk_req("reset_request", requests.reset_request, 1'b0);
    wr(12'h000, 8'h61);
    rd(12'h000, 8'hA1);
    supply_mv <= 16'h0CE4; // 3300 mV
    settle();
    wr(12'h000, 8'h61);
    rd(12'h000, 8'h21);
    wr(12'h004, 8'h40);
  endtask

  task automatic t_warning();
    wr(12'h004, 8'h23);
    supply_mv <= 16'h0ABE; // 2750 mV, below warning levels 0 to 2, above level 3
    settle();
    rd(12'h004, 8'h23);
    chk_req("warning_irq", requests.warning_irq, 1'b0);
    wr(12'h004, 8'h22);
    settle();
    rd(12'h004, 8'hA2);
    chk_req("warning_irq", requests.warning_irq, 1'b1);
    wr(12'h004, 8'h62);
    rd(12'h004, 8'hA2);
    supply_mv <= 16'h0CE4;
    settle();
    wr(12'h004, 8'h62);
    rd(12'h004, 8'h22);
  endtask

  // Both low-power modes must mask a detection
  task automatic t_modes();
    for (int m = 1; m < 3; m++) begin
      wr(12'h00C, 8'(m));
      rd(12'h00C, 8'(m));
      supply_mv <= 16'h09C4;
      settle();
      rd(12'h000, 8'h21);
      supply_mv <= 16'h0CE4;
      wr(12'h00C, 8'h00);
      wr(12'h004, 8'h62);
    end
  endtask

  task automatic t_lvd_reset();
    do_reset();
    supply_mv <= 16'h05DC; // 1500 mV
    settle();
    chk_req("reset_request", requests.reset_request, 1'b1);
    chk_req("source", requests.reset_source_lowsupply, 1'b1);
    repeat (20) @(posedge pclk);
    chk_req("reset_request", requests.reset_request, 1'b1);
    rd(12'h008, 8'h1F);
    supply_mv <= 16'h0CE4;
    settle();
    chk_req("reset_request", requests.reset_request, 1'b0);
    do_reset();
    chk_req("source", requests.reset_source_lowsupply, 1'b0);
    power_on_reset_seen <= 1'b1;
    settle();
    chk_req("source", requests.reset_source_lowsupply, 1'b1);
    power_on_reset_seen <= 1'b0;
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    pprot = 3'h1;
    power_on_reset_seen = 1'b0;
    supply_mv = 16'h0CE4;
    do_reset();
    t_regs();
    t_detect();
    t_warning();
    t_modes();
    t_lvd_reset();
    give_verdict();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
